// >>> monitor_pkg.sv
// constants and types for the power monitor conversion sequencer
package monitor_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLOCK_HZ = 100_000_000;
  localparam int unsigned RECOVERY_MS = 40;
  localparam longint unsigned RECOVERY_CYCLES_DEF = longint'(RECOVERY_MS) * CLOCK_HZ / 1000;
  // ==========================================================
  // register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_SHUNT = 8'h04;
  localparam logic [7:0] ADDR_BUS = 8'h08;
  localparam logic [7:0] ADDR_CURRENT = 8'h0C;
  localparam logic [7:0] ADDR_POWER = 8'h10;
  localparam logic [7:0] ADDR_CALIB = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ==========================================================
  // config layout: mode, shunt time, bus time, averaging
  localparam int CFG_W = 12;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SCT_LSB = 3;
  localparam int CFG_BCT_LSB = 6;
  localparam int CFG_AVG_LSB = 9;
  localparam logic [11:0] CFG_RESET = 12'h127;
  localparam int MODE_SHUNT_BIT = 0;
  localparam int MODE_BUS_BIT = 1;
  localparam int MODE_CONT_BIT = 2;
  // ==========================================================
  // status bits
  localparam int STAT_READY = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_RECOVER = 2;
  // ==========================================================
  // arithmetic
  localparam int DATA_W = 16;
  localparam int AVG_MAX_SHIFT = 10;
  localparam int ACC_W = DATA_W + AVG_MAX_SHIFT;
  localparam int CUR_SHIFT = 11;
  localparam int PWR_SHIFT = 13;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_RECOVER, ST_LAUNCH, ST_WAIT, ST_SAMPLE} seq_state_type;
  // averaging code to log2 of sample count
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction
endpackage

// >>> power_monitor_conversion_sequencer.sv
// conversion sequencer with ahb-lite register slave
`timescale 1ns/10ps
module power_monitor_conversion_sequencer #(
  parameter longint unsigned RECOVERY_CYCLES = monitor_pkg::RECOVERY_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic conv_start,
  output logic conv_bus,
  output logic [2:0] conv_time,
  output logic front_end_on,
  input wire logic conv_done,
  input wire logic [monitor_pkg::DATA_W-1:0] conv_data
);
  import monitor_pkg::*;

  localparam int RW = $clog2(RECOVERY_CYCLES + 1);

  typedef struct packed {
    seq_state_type state;
    logic [CFG_W-1:0] cfg;
    logic [DATA_W-1:0] cal;
    logic [DATA_W-1:0] shunt_out;
    logic [DATA_W-1:0] bus_out;
    logic [DATA_W-1:0] cur_out;
    logic [DATA_W-1:0] pwr_out;
    logic ready;
    logic [ACC_W-1:0] acc_sh;
    logic [ACC_W-1:0] acc_bus;
    logic [ACC_W-1:0] acc_cur;
    logic [ACC_W-1:0] acc_pwr;
    logic [DATA_W-1:0] cur_last;
    logic [AVG_MAX_SHIFT:0] samples;
    logic [RW-1:0] rec_cnt;
    logic single;
    logic chan;
    logic start;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic [DATA_W-1:0] data_s1;
    logic [DATA_W-1:0] data_s2;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic rdy;
    logic [2:0] ctime;
    logic fe_on;
  } seq_struct_type;

  seq_struct_type s_ff;
  seq_struct_type nxt_s;

  logic [2:0] mode;
  logic shunt_en;
  logic bus_en;
  logic cont_en;
  logic pd;
  logic done_rise;
  logic access;
  logic rd_access;
  logic cfg_wr;
  logic stat_rd;
  logic publish;
  logic [2:0] new_mode;
  logic signed [2*DATA_W:0] cur_prod;
  logic signed [2*DATA_W:0] cur_sh;
  logic signed [2*DATA_W:0] pwr_prod;
  logic signed [2*DATA_W:0] pwr_sh;
  logic [DATA_W-1:0] cur_val;
  logic [DATA_W-1:0] pwr_val;
  logic [3:0] shift;
  logic [AVG_MAX_SHIFT:0] avg_count;
  logic [ACC_W-1:0] avg_sh;
  logic [ACC_W-1:0] avg_bus;
  logic [ACC_W-1:0] avg_cur;
  logic [ACC_W-1:0] avg_pwr;
  logic [31:0] rmux;

  // ==========================================================
  // decode
  assign mode = s_ff.cfg[CFG_MODE_LSB +: 3];
  assign shunt_en = mode[MODE_SHUNT_BIT];
  assign bus_en = mode[MODE_BUS_BIT];
  assign cont_en = mode[MODE_CONT_BIT];
  assign pd = !shunt_en && !bus_en;
  assign done_rise = s_ff.done_s2 && !s_ff.done_s3;
  assign access = hsel && hready && htrans[1];
  assign rd_access = access && !hwrite;
  assign cfg_wr = s_ff.wr_pend && (s_ff.wr_addr == ADDR_CONFIG);
  assign stat_rd = rd_access && (haddr[ADDR_W-1:0] == ADDR_STATUS);
  assign new_mode = hwdata[CFG_MODE_LSB +: 3];
  assign shift = avg_shift(s_ff.cfg[CFG_AVG_LSB +: 3]);
  assign avg_count = (AVG_MAX_SHIFT + 1)'(1) << shift;

  // ==========================================================
  // background math, same cycle as the sample
  always_comb begin
    cur_prod = $signed(s_ff.data_s2) * $signed({1'b0, s_ff.cal});
    cur_sh = cur_prod >>> CUR_SHIFT;
    cur_val = (s_ff.cal == '0) ? '0 : cur_sh[DATA_W-1:0];
    pwr_prod = $signed(s_ff.cur_last) * $signed({1'b0, s_ff.data_s2});
    pwr_sh = pwr_prod >>> PWR_SHIFT;
    pwr_val = (s_ff.cal == '0) ? '0 : pwr_sh[DATA_W-1:0];
    avg_sh = $signed(s_ff.acc_sh) >>> shift;
    avg_bus = s_ff.acc_bus >> shift;
    avg_cur = $signed(s_ff.acc_cur) >>> shift;
    avg_pwr = $signed(s_ff.acc_pwr) >>> shift;
  end

  // ==========================================================
  // read mux
  always_comb begin
    rmux = '0;
    case (haddr[ADDR_W-1:0])
      ADDR_CONFIG: rmux[CFG_W-1:0] = s_ff.cfg;
      ADDR_SHUNT: rmux[DATA_W-1:0] = s_ff.shunt_out;
      ADDR_BUS: rmux[DATA_W-1:0] = s_ff.bus_out;
      ADDR_CURRENT: rmux[DATA_W-1:0] = s_ff.cur_out;
      ADDR_POWER: rmux[DATA_W-1:0] = s_ff.pwr_out;
      ADDR_CALIB: rmux[DATA_W-1:0] = s_ff.cal;
      ADDR_STATUS: begin
        rmux[STAT_READY] = s_ff.ready;
        rmux[STAT_BUSY] = (s_ff.state != ST_IDLE);
        rmux[STAT_RECOVER] = (s_ff.state == ST_RECOVER);
      end
      default: rmux = '0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    publish = 1'b0;
    nxt_s.start = 1'b0;
    nxt_s.done_s1 = conv_done;
    nxt_s.done_s2 = s_ff.done_s1;
    nxt_s.done_s3 = s_ff.done_s2;
    nxt_s.data_s1 = conv_data;
    nxt_s.data_s2 = s_ff.data_s1;
    nxt_s.rdy = 1'b1;
    // bus address phase
    nxt_s.wr_pend = access && hwrite;
    nxt_s.wr_addr = haddr[ADDR_W-1:0];
    if (rd_access) begin
      nxt_s.rdata = rmux;
    end
    if (stat_rd) begin
      nxt_s.ready = 1'b0;
    end
    // sequencer
    case (s_ff.state)
      ST_IDLE: begin
        if (!pd && (cont_en || s_ff.single)) begin
          nxt_s.chan = !shunt_en;
          nxt_s.state = ST_LAUNCH;
        end
      end
      ST_RECOVER: begin
        if (s_ff.rec_cnt == '0) begin
          nxt_s.state = ST_IDLE;
        end else begin
          nxt_s.rec_cnt = s_ff.rec_cnt - RW'(1);
        end
      end
      ST_LAUNCH: begin
        nxt_s.start = 1'b1;
        nxt_s.state = ST_WAIT;
      end
      ST_WAIT: begin
        if (done_rise) begin
          if (!s_ff.chan) begin
            nxt_s.acc_sh = s_ff.acc_sh + ACC_W'($signed(s_ff.data_s2));
            nxt_s.acc_cur = s_ff.acc_cur + ACC_W'($signed(cur_val));
            nxt_s.cur_last = cur_val;
            if (bus_en) begin
              nxt_s.chan = 1'b1;
              nxt_s.state = ST_LAUNCH;
            end else begin
              nxt_s.state = ST_SAMPLE;
            end
          end else begin
            nxt_s.acc_bus = s_ff.acc_bus + ACC_W'(s_ff.data_s2);
            nxt_s.acc_pwr = s_ff.acc_pwr + ACC_W'($signed(pwr_val));
            nxt_s.state = ST_SAMPLE;
          end
        end
      end
      ST_SAMPLE: begin
        nxt_s.chan = !shunt_en;
        nxt_s.state = ST_LAUNCH;
        if (s_ff.samples + (AVG_MAX_SHIFT + 1)'(1) == avg_count) begin
          publish = 1'b1;
          nxt_s.samples = '0;
          nxt_s.acc_sh = '0;
          nxt_s.acc_bus = '0;
          nxt_s.acc_cur = '0;
          nxt_s.acc_pwr = '0;
          nxt_s.single = 1'b0;
          if (!cont_en) begin
            nxt_s.state = ST_IDLE;
          end
        end else begin
          nxt_s.samples = s_ff.samples + (AVG_MAX_SHIFT + 1)'(1);
        end
      end
      default: nxt_s.state = ST_IDLE;
    endcase
    // bus data phase, writable in any mode
    if (s_ff.wr_pend) begin
      if (s_ff.wr_addr == ADDR_CALIB) begin
        nxt_s.cal = hwdata[DATA_W-1:0];
      end
      if (cfg_wr) begin
        nxt_s.cfg = hwdata[CFG_W-1:0];
        nxt_s.samples = '0;
        nxt_s.acc_sh = '0;
        nxt_s.acc_bus = '0;
        nxt_s.acc_cur = '0;
        nxt_s.acc_pwr = '0;
        nxt_s.single = new_mode[MODE_SHUNT_BIT] || new_mode[MODE_BUS_BIT];
        nxt_s.state = ST_IDLE;
        nxt_s.start = 1'b0;
        if (nxt_s.single) begin
          nxt_s.ready = 1'b0;
          if (pd || s_ff.state == ST_RECOVER) begin
            nxt_s.state = ST_RECOVER;
            nxt_s.rec_cnt = RW'(RECOVERY_CYCLES);
          end
        end
      end
    end
    // completion: shunt and current outputs if shunt enabled, bus and power outputs if bus enabled, set beats clear
    if (publish) begin
      nxt_s.ready = 1'b1;
      if (shunt_en) begin
        nxt_s.shunt_out = avg_sh[DATA_W-1:0];
        nxt_s.cur_out = avg_cur[DATA_W-1:0];
      end
      if (bus_en) begin
        nxt_s.bus_out = avg_bus[DATA_W-1:0];
        nxt_s.pwr_out = avg_pwr[DATA_W-1:0];
      end
    end
    // link outputs registered from next channel and mode
    nxt_s.ctime = nxt_s.chan ? nxt_s.cfg[CFG_BCT_LSB +: 3] : nxt_s.cfg[CFG_SCT_LSB +: 3];
    nxt_s.fe_on = nxt_s.cfg[CFG_MODE_LSB + MODE_SHUNT_BIT] || nxt_s.cfg[CFG_MODE_LSB + MODE_BUS_BIT];
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.cfg <= CFG_RESET;
      s_ff.rdy <= 1'b1;
      s_ff.ctime <= CFG_RESET[CFG_SCT_LSB +: 3];
      s_ff.fe_on <= CFG_RESET[CFG_MODE_LSB + MODE_SHUNT_BIT] || CFG_RESET[CFG_MODE_LSB + MODE_BUS_BIT];
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign hrdata = s_ff.rdata;
  assign hreadyout = s_ff.rdy;
  assign hresp = 1'b0;
  assign conv_start = s_ff.start;
  assign conv_bus = s_ff.chan;
  assign conv_time = s_ff.ctime;
  assign front_end_on = s_ff.fe_on;

  // ==========================================================
  // checks
  sequence seq_publish;
    ce && publish;
  endsequence
  sequence seq_cfg_active;
    ce && cfg_wr && (hwdata[CFG_MODE_LSB +: 2] != 2'h0) && !publish;
  endsequence

  chk_ready_sets: assert property (@(posedge clock) disable iff (!rst_n)
    seq_publish |=> s_ff.ready) else $error("ready flag not set at completion");
  chk_cfg_clears: assert property (@(posedge clock) disable iff (!rst_n)
    seq_cfg_active |=> !s_ff.ready) else $error("config write left ready set");
  chk_status_clears: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && stat_rd && !publish && !cfg_wr) |=> !s_ff.ready) else $error("status read left ready set");
  chk_outputs_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (!publish || !ce) |=> $stable(s_ff.shunt_out) && $stable(s_ff.bus_out) && $stable(s_ff.cur_out)
    && $stable(s_ff.pwr_out)) else $error("output changed early");
  chk_cal_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && s_ff.cal == '0 && s_ff.state == ST_WAIT && done_rise && !cfg_wr)
    |=> $stable(s_ff.acc_cur) && $stable(s_ff.acc_pwr))
    else $error("current or power summed without calibration");
  chk_start_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && conv_start) |=> !conv_start) else $error("start longer than one cycle");
  chk_wait_done: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && s_ff.state == ST_WAIT && !done_rise && !cfg_wr) |=> s_ff.state == ST_WAIT)
    else $error("left wait without done");
  chk_recover_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (s_ff.state == ST_RECOVER && s_ff.rec_cnt != '0) |=> !conv_start) else $error("start during recovery");
  chk_pd_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (pd && !s_ff.wr_pend && s_ff.state == ST_IDLE) |=> s_ff.state == ST_IDLE) else $error("power-down not idle");
  chk_shunt_then_bus: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && s_ff.state == ST_WAIT && done_rise && !s_ff.chan && bus_en && !cfg_wr) |=> conv_bus ##1 conv_start)
    else $error("bus conversion did not follow shunt");
  chk_single_stops: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && publish && !cont_en && !cfg_wr) |=> s_ff.state == ST_IDLE)
    else $error("triggered set did not go idle");
  chk_pd_front_off: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && cfg_wr && (hwdata[CFG_MODE_LSB +: 2] == 2'h0)) |=> !front_end_on)
    else $error("front end left on in power-down");
  chk_recover_exit: assert property (@(posedge clock) disable iff (!rst_n)
    (ce && s_ff.state == ST_RECOVER && s_ff.rec_cnt == '0 && !cfg_wr) |=> s_ff.state == ST_IDLE)
    else $error("recovery did not end on count");
endmodule

// >>> converter_model.sv
// behavioural model of the analogue converter front end
`timescale 1ns/10ps
module converter_model #(
  parameter int DELAY = 12
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic conv_bus,
  input wire logic [2:0] conv_time,
  input wire logic front_end_on,
  input wire logic [15:0] shunt_val,
  input wire logic [15:0] bus_val,
  input wire logic wobble,
  output logic conv_done,
  output logic [15:0] conv_data
);
  int cnt;
  logic busy;
  logic chan;
  logic tog;
  // ==========================================================
  // conversion timing and result
  always @(posedge clock) begin
    if (!rst_n) begin
      busy <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
      cnt <= 0;
      tog <= 1'b0;
      chan <= 1'b0;
    end else if (!front_end_on) begin
      busy <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end else if (conv_start) begin
      busy <= 1'b1;
      chan <= conv_bus;
      cnt <= DELAY + int'(conv_time);
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end else if (busy) begin
      cnt <= cnt - 1;
      if (cnt == 3) begin
        conv_data <= chan ? bus_val : shunt_val + {14'h0000, tog, 1'b0};
      end
      if (cnt == 1) begin
        conv_done <= 1'b1;
        busy <= 1'b0;
        if (!chan && wobble) begin
          tog <= ~tog;
        end
      end
    end
  end
endmodule

// >>> tb.sv
// self-checking testbench of the conversion sequencer
`timescale 1ns/10ps
module tb;
  import monitor_pkg::*;
  localparam int REC = 20;
  logic clock, rst_n, ce, hsel, hwrite, hreadyout, hresp, conv_start, conv_bus, front_end_on, conv_done, wobble;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0] htrans;
  logic [2:0] hsize, conv_time;
  logic [15:0] conv_data, shunt_val, bus_val;
  logic [2:0] t_seen;
  int miscompares, n_compared, n_starts, n_bus, base, bbase, cycles, m;
  power_monitor_conversion_sequencer #(.RECOVERY_CYCLES(REC)) dut (.clock(clock), .rst_n(rst_n), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start),
    .conv_bus(conv_bus), .conv_time(conv_time), .front_end_on(front_end_on), .conv_done(conv_done),
    .conv_data(conv_data));
  converter_model fe (.clock(clock), .rst_n(rst_n), .conv_start(conv_start), .conv_bus(conv_bus),
    .conv_time(conv_time), .front_end_on(front_end_on), .shunt_val(shunt_val), .bus_val(bus_val),
    .wobble(wobble), .conv_done(conv_done), .conv_data(conv_data));
  // ==========================================================
  // clock, start counting, timeout
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge clock) begin
    cycles++;
    if (conv_start === 1'b1) begin
      n_starts++;
      t_seen = conv_time;
      if (conv_bus === 1'b1) n_bus++;
    end
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h00000000);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] exp, input int bitmask);
    for (int k = 0; k < 500; k++) begin
      rd(a);
      if ((rdata & bitmask) === exp) break;
    end
    check(rdata & bitmask, exp);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    ce = 1'b1; rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; wobble = 1'b0; shunt_val = 16'h0100; bus_val = 16'h4000;
    miscompares = 0; n_compared = 0; n_starts = 0; n_bus = 0; cycles = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd(ADDR_CONFIG); check(rdata, 32'h127);
    rd(ADDR_CALIB); check(rdata, 32'h0);
    poll(ADDR_STATUS, 32'h1, 1);
    poll(ADDR_STATUS, 32'h1, 1);
    check(32'(n_starts >= 4), 32'h1);
    check(32'(t_seen), 32'h4);
    rd(ADDR_CURRENT); check(rdata, 32'h0);
    rd(ADDR_POWER); check(rdata, 32'h0);
    rd(ADDR_SHUNT); check(rdata, 32'h100);
    rd(ADDR_BUS); check(rdata, 32'h4000);
    xfer(1'b1, ADDR_CONFIG, 32'h0);
    base = n_starts;
    xfer(1'b1, ADDR_CALIB, 32'h1000);
    rd(ADDR_CALIB); check(rdata, 32'h1000);
    check(32'(hresp), 32'h0);
    repeat (50) @(posedge clock);
    check(32'(n_starts - base), 32'h0);
    check(32'(front_end_on), 32'h0);
    base = n_starts; bbase = n_bus;
    xfer(1'b1, ADDR_CONFIG, 32'h3);
    repeat (REC - 2) @(posedge clock);
    check(32'(n_starts - base), 32'h0);
    poll(ADDR_CURRENT, 32'h200, -1);
    rd(ADDR_POWER); check(rdata, 32'h400);
    rd(ADDR_SHUNT); check(rdata, 32'h100);
    rd(ADDR_BUS); check(rdata, 32'h4000);
    check(32'(n_starts - base), 32'h2);
    check(32'(n_bus - bbase), 32'h1);
    xfer(1'b1, ADDR_CONFIG, 32'h0);
    rd(ADDR_STATUS); check(rdata & 1, 32'h1);
    rd(ADDR_STATUS); check(rdata & 1, 32'h0);
    shunt_val <= 16'h0080;
    xfer(1'b1, ADDR_CONFIG, 32'h3);
    poll(ADDR_CURRENT, 32'h100, -1);
    xfer(1'b1, ADDR_CONFIG, 32'h3);
    rd(ADDR_STATUS); check(rdata & 1, 32'h0);
    poll(ADDR_STATUS, 32'h1, 1);
    rd(ADDR_STATUS); check(rdata & 1, 32'h0);
    shunt_val <= 16'h0100;
    wobble <= 1'b1;
    base = n_starts;
    xfer(1'b1, ADDR_CONFIG, 32'h203);
    while (n_starts - base < 4) @(posedge clock);
    rd(ADDR_CURRENT); check(rdata, 32'h100);
    rd(ADDR_SHUNT); check(rdata, 32'h80);
    poll(ADDR_CURRENT, 32'h202, -1);
    rd(ADDR_SHUNT); check(rdata, 32'h101);
    rd(ADDR_POWER); check(rdata, 32'h404);
    check(32'(n_starts - base), 32'h8);
    wobble <= 1'b0;
    for (m = 1; m <= 2; m++) begin
      base = n_starts; bbase = n_bus;
      xfer(1'b1, ADDR_CONFIG, 32'h158 + 32'(m));
      poll(ADDR_STATUS, 32'h1, 1);
      check(32'(t_seen), 32'(2 * m + 1));
      check(32'(n_starts - base), 32'h1);
      check(32'(n_bus - bbase), 32'(m - 1));
    end
    give_verdict();
  end
endmodule
